// ===== ric_pkg.sv
// Constants, register map and state types for the reset and irq control.
// Assumes a single core clock; included by the one design module.
package ric_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h00;
  localparam logic [7:0] OFS_EXT_MASK = 8'h01;
  localparam logic [7:0] OFS_EXT_FLAGS = 8'h02;
  localparam logic [7:0] OFS_CORE_CONTROL = 8'h03;
  localparam logic [7:0] OFS_CORE_STATUS = 8'h04;

  // Field positions
  localparam int POWERUP_SEEN_BIT = 0;
  localparam int PIN_SEEN_BIT = 1;
  localparam int EXT_ZERO_BIT = 6;
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam int SENSE_WIDTH = 2;

  // Reset values
  localparam logic POWERUP_SEEN_RESET = 1'b1;
  localparam logic PIN_SEEN_RESET = 1'b0;
  localparam logic [1:0] EXT_MASK_RESET = 2'h0;
  localparam logic [1:0] EXT_FLAGS_RESET = 2'h0;
  localparam logic [3:0] SENSE_RESET = 4'h0;
  localparam logic GLOBAL_ENABLE_RESET = 1'b0;

  // Sense modes per request line
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_ANY_CHANGE = 2'h1;
  localparam logic [1:0] SENSE_FALLING = 2'h2;
  localparam logic [1:0] SENSE_RISING = 2'h3;

  // Vector addresses
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_EXT_ZERO = 5'h01;
  localparam logic [4:0] VEC_EXT_ONE = 5'h02;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int PIN_RESET_MIN_NS = 50;
  localparam int PIN_LOW_CYCLES =
    (PIN_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_STARTUP_TICKS = 1024;
  localparam int LONG_STARTUP_TICKS = 16384;

  typedef enum logic [1:0] {
    ST_PIN_HOLD,
    ST_DELAY,
    ST_RUN,
    ST_WDOG_PULSE
  } ric_phase_t;

  typedef struct packed {
    ric_phase_t phase;
    logic [14:0] delayCnt;
    logic tickPrev;
    logic [2:0] pinLowCnt;
    logic powerupSeen;
    logic pinSeen;
    logic [1:0] extMask;
    logic [1:0] extFlags;
    logic [3:0] sense;
    logic globalEnable;
    logic [1:0] extPrev;
    logic [7:0] readData;
    logic irqRequest;
    logic [4:0] irqVector;
  } ric_state_t;

endpackage

// ===== ric_top.sv
// Reset sequencing, reset-cause flags and external interrupt arbitration.
// Assumes all inputs synchronous to clk except the reset pin's direct path.
// Contract
// - Reset pin low beyond 50 ns resets, even clockless; short pulses optional.
// - Enabled watchdog expiry resets the device.
// - Reset loads initial values; execution restarts at vector zero.
// - Start-up delay is 1K ticks with fuse programmed, else 16K.
// - Pin release starts delay; core released after full count.
// - Pin held low after power-up postpones the delay count.
// - Watchdog reset pulse lasts one clock; its end starts the delay.
// - Reset-cause bits seven to two read zero.
// - Pin flag set by pin reset only, kept on watchdog, cleared writing zero.
// - Power-up flag set by power-on only, kept otherwise, cleared writing zero.
// - Taking an irq clears global enable; return sets it; software may set.
// - Vectoring clears the serviced source's pending flag.
// - Masked conditions still set flags that stay pending.
// - Pending flags wait for global enable, then serve by priority.
// - Lower vector wins; reset highest, request zero next.
// - Level-sensed request has no flag, exists only while pin low.
// - Request one serves from vector two when mask bit 7 and enable set.
// - Request zero serves from vector one when mask bit 6 and enable set.
// - Pin activity requests even when pin drives as output.
// - Mask bits five to zero read zero.
// - Edge or change on a pin sets its flag, bit 7 or bit 6.
// - Low-level sensing holds the flag at zero.
// - Edge flags clear on routine entry or on writing one.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module ric_top
  import ric_pkg::*;
#(
  parameter int ShortTicks = SHORT_STARTUP_TICKS,
  parameter int LongTicks = LONG_STARTUP_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic resetPinN,
  input wire logic watchdogEnable,
  input wire logic watchdogExpire,
  input wire logic watchdogOscillator,
  input wire logic shortStartupFuse,
  input wire logic [1:0] extPin,
  input wire logic irqTake,
  input wire logic returnFromIrq,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  output logic coreReset,
  output logic irqRequest,
  output logic [4:0] irqVector,
  output logic globalEnable
);

  localparam logic [14:0] SHORT_LAST = 15'(ShortTicks - 1);
  localparam logic [14:0] LONG_LAST = 15'(LongTicks - 1);
  localparam logic [2:0] PIN_LOW_LAST = 3'(PIN_LOW_CYCLES - 1);

  localparam ric_state_t STATE_RESET = '{
    phase: ST_PIN_HOLD,
    delayCnt: 15'h0000,
    tickPrev: 1'b0,
    pinLowCnt: 3'h0,
    powerupSeen: POWERUP_SEEN_RESET,
    pinSeen: PIN_SEEN_RESET,
    extMask: EXT_MASK_RESET,
    extFlags: EXT_FLAGS_RESET,
    sense: SENSE_RESET,
    globalEnable: GLOBAL_ENABLE_RESET,
    extPrev: 2'h0,
    readData: 8'h00,
    irqRequest: 1'b0,
    irqVector: VEC_RESET
  };

  ric_state_t s;
  ric_state_t next_s;

  logic pinLow;
  logic pinQualified;
  logic tickRise;
  logic [14:0] delayLast;
  logic [1:0] senseMode;
  logic trig;
  logic [1:0] levelReq;
  logic [1:0] pending;
  logic inReset;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_s = s;
    senseMode = SENSE_LOW_LEVEL;
    trig = 1'b0;
    levelReq = 2'h0;
    pending = 2'h0;
    pinLow = ~resetPinN;
    tickRise = watchdogOscillator & ~s.tickPrev;
    next_s.tickPrev = watchdogOscillator;
    delayLast = shortStartupFuse ? SHORT_LAST : LONG_LAST;

    // Qualify the pin: only a low lasting the minimum counts as pin reset
    if (!pinLow) begin
      next_s.pinLowCnt = 3'h0;
    end else if (s.pinLowCnt != PIN_LOW_LAST) begin
      next_s.pinLowCnt = s.pinLowCnt + 3'h1;
    end
    pinQualified = pinLow && (s.pinLowCnt == PIN_LOW_LAST);

    unique case (s.phase)
      ST_PIN_HOLD: begin
        next_s.delayCnt = 15'h0000;
        if (!pinLow) begin
          next_s.phase = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (tickRise) begin
          if (s.delayCnt >= delayLast) begin
            next_s.phase = ST_RUN;
          end else begin
            next_s.delayCnt = s.delayCnt + 15'h0001;
          end
        end
      end
      ST_RUN: begin
        if (watchdogEnable && watchdogExpire) begin
          next_s.phase = ST_WDOG_PULSE;
        end
      end
      ST_WDOG_PULSE: begin
        // One-clock pulse; its trailing edge starts the delay
        next_s.phase = ST_DELAY;
        next_s.delayCnt = 15'h0000;
      end
    endcase

    if (pinQualified) begin
      next_s.phase = ST_PIN_HOLD;
      next_s.delayCnt = 15'h0000;
    end

    // Reset-cause flags: write zero clears, hardware set wins
    if (regWrite && regAddr == OFS_RESET_CAUSE) begin
      if (!regWriteData[POWERUP_SEEN_BIT]) begin
        next_s.powerupSeen = 1'b0;
      end
      if (!regWriteData[PIN_SEEN_BIT]) begin
        next_s.pinSeen = 1'b0;
      end
    end
    if (pinQualified) begin
      next_s.pinSeen = 1'b1;
    end

    // Software-visible control registers
    if (regWrite && regAddr == OFS_EXT_MASK) begin
      next_s.extMask = regWriteData[EXT_ZERO_BIT +: 2];
    end
    if (regWrite && regAddr == OFS_CORE_CONTROL) begin
      next_s.sense = regWriteData[3:0];
    end
    if (regWrite && regAddr == OFS_CORE_STATUS) begin
      next_s.globalEnable = regWriteData[GLOBAL_ENABLE_BIT];
    end
    if (returnFromIrq) begin
      next_s.globalEnable = 1'b1;
    end
    if (irqTake) begin
      next_s.globalEnable = 1'b0;
    end

    // Pad level is seen whatever the pin direction
    for (int i = 0; i < 2; i++) begin
      senseMode = next_s.sense[SENSE_WIDTH*i +: SENSE_WIDTH];
      unique case (senseMode)
        SENSE_LOW_LEVEL: trig = 1'b0;
        SENSE_ANY_CHANGE: trig = extPin[i] ^ s.extPrev[i];
        SENSE_FALLING: trig = ~extPin[i] & s.extPrev[i];
        SENSE_RISING: trig = extPin[i] & ~s.extPrev[i];
      endcase
      if (senseMode == SENSE_LOW_LEVEL) begin
        next_s.extFlags[i] = 1'b0;
        levelReq[i] = ~extPin[i];
      end else begin
        if (regWrite && regAddr == OFS_EXT_FLAGS
            && regWriteData[EXT_ZERO_BIT + i]) begin
          next_s.extFlags[i] = 1'b0;
        end
        if (irqTake && s.irqVector == VEC_EXT_ZERO + 5'(i)) begin
          next_s.extFlags[i] = 1'b0;
        end
        if (trig) begin
          next_s.extFlags[i] = 1'b1;
        end
      end
    end
    next_s.extPrev = extPin;

    // Core reset returns mask, edge flags, sense and global enable to initial values; reset-cause flags kept
    inReset = (next_s.phase != ST_RUN) || pinLow;
    if (inReset) begin
      next_s.extMask = EXT_MASK_RESET;
      next_s.extFlags = EXT_FLAGS_RESET;
      next_s.sense = SENSE_RESET;
      next_s.globalEnable = GLOBAL_ENABLE_RESET;
      levelReq = 2'h0;
    end

    pending = next_s.extMask & (next_s.extFlags | levelReq);
    next_s.irqRequest = next_s.globalEnable && (pending != 2'h0);
    if (pending[0]) begin
      next_s.irqVector = VEC_EXT_ZERO;
    end else if (pending[1]) begin
      next_s.irqVector = VEC_EXT_ONE;
    end else begin
      next_s.irqVector = VEC_RESET;
    end

    // Read data stands only in the cycle after the strobe
    next_s.readData = 8'h00;
    if (regRead) begin
      unique case (regAddr)
        OFS_RESET_CAUSE: next_s.readData =
          {6'h00, s.pinSeen, s.powerupSeen};
        OFS_EXT_MASK: next_s.readData = {s.extMask, 6'h00};
        OFS_EXT_FLAGS: next_s.readData = {s.extFlags, 6'h00};
        OFS_CORE_CONTROL: next_s.readData = {4'h0, s.sense};
        OFS_CORE_STATUS: next_s.readData = {s.globalEnable, 7'h00};
        default: next_s.readData = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Direct pin path keeps the core in reset with no clock running
  assign coreReset = (s.phase != ST_RUN) | ~resetPinN;
  assign regReadData = s.readData;
  assign irqRequest = s.irqRequest;
  assign irqVector = s.irqVector;
  assign globalEnable = s.globalEnable;

endmodule

`default_nettype wire

// ===== ric_pin_model.sv
// Far-side model: reset pin with pull-up and the two request pads.
// Assumes the bench changes its controls right after a clock edge.
`timescale 1ns/1ns
`default_nettype none

module ric_pin_model (
  input wire logic holdLow,
  input wire logic [1:0] level,
  output logic resetPinN,
  output logic [1:0] extPin
);
  // Pull-up: a released pin reads high
  assign resetPinN = !holdLow;
  // Pads toggle freely, as a port driven as output would
  assign extPin = level;
endmodule

`default_nettype wire

// ===== ric_top_asserts.sv
// Checker for the reset and irq control, bound to the top module.
// Assumes one clock and the active-high asynchronous reset.
`timescale 1ns/1ns
`default_nettype none

module ric_top_asserts
  import ric_pkg::*;
#(
  parameter int ShortTicks = SHORT_STARTUP_TICKS,
  parameter int LongTicks = LONG_STARTUP_TICKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic resetPinN,
  input wire logic watchdogEnable,
  input wire logic watchdogExpire,
  input wire logic irqTake,
  input wire logic returnFromIrq,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  input wire logic coreReset,
  input wire logic irqRequest,
  input wire logic [4:0] irqVector,
  input wire logic globalEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_pin_low_reset: assert property (!resetPinN |-> coreReset)
    else $error("core not in reset while pin low");
  // Long low then release: start-up delay must still hold the core
  chk_delay_after_pin: assert property (
    !resetPinN [*8] ##1 resetPinN |-> coreReset [*4])
    else $error("core left reset too soon after pin release");
  chk_watchdog_reset: assert property (
    !coreReset && watchdogEnable && watchdogExpire |=> coreReset [*2])
    else $error("watchdog expiry did not reset");
  chk_cause_high_zero: assert property (
    regRead && regAddr == OFS_RESET_CAUSE |=> regReadData[7:2] == 6'h00)
    else $error("reset cause upper bits not zero");
  chk_mask_low_zero: assert property (
    regRead && regAddr == OFS_EXT_MASK |=> regReadData[5:0] == 6'h00)
    else $error("mask low bits not zero");
  chk_take_clears_enable: assert property (
    irqTake |=> !globalEnable && !irqRequest)
    else $error("taking irq left enable or request");
  chk_return_sets_enable: assert property (
    returnFromIrq && !irqTake && !coreReset
      && !(watchdogEnable && watchdogExpire) |=> globalEnable)
    else $error("return did not set enable");
  chk_req_needs_enable: assert property (
    irqRequest |-> globalEnable || $past(globalEnable))
    else $error("request without global enable");
  chk_idle_vector_zero: assert property (
    irqVector == VEC_RESET |-> !irqRequest)
    else $error("request without a vector");
  chk_status_read_enable: assert property (
    regRead && regAddr == OFS_CORE_STATUS
      |=> regReadData == {$past(globalEnable), 7'h00})
    else $error("status read mismatch");
endmodule

`default_nettype wire

// ===== tb.sv
// Self-checking bench for the reset and irq control.
// Assumes the pin model and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none

module tb;
  import ric_pkg::*;
  localparam int ShortTicks = 4;
  localparam int LongTicks = 8;
  logic clk, rst, watchdogEnable, watchdogExpire, watchdogOscillator;
  logic shortStartupFuse, irqTake, returnFromIrq, regWrite, regRead;
  logic holdLow, resetPinN, coreReset, irqRequest, globalEnable;
  logic [1:0] pinLvl, extPin;
  logic [7:0] regAddr, regWriteData, regReadData;
  logic [4:0] irqVector;
  logic [1:0] mode;
  logic line, fell;
  int bad_count, n_tests, seed;

  ric_pin_model ric_pin_model_i (.holdLow(holdLow), .level(pinLvl),
    .resetPinN(resetPinN), .extPin(extPin));
  ric_top #(.ShortTicks(ShortTicks), .LongTicks(LongTicks)) ric_top_i (
    .clk(clk), .rst(rst), .resetPinN(resetPinN),
    .watchdogEnable(watchdogEnable), .watchdogExpire(watchdogExpire),
    .watchdogOscillator(watchdogOscillator),
    .shortStartupFuse(shortStartupFuse), .extPin(extPin),
    .irqTake(irqTake), .returnFromIrq(returnFromIrq), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .coreReset(coreReset),
    .irqRequest(irqRequest), .irqVector(irqVector),
    .globalEnable(globalEnable));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {regAddr, regWriteData, regWrite} <= {a, d, 1'b1};
    @(posedge clk) regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) {regAddr, regRead} <= {a, 1'b1};
    @(posedge clk) regRead <= 1'b0;
    #1 check(regReadData, exp);
  endtask
  task automatic pulse(input bit ret);
    @(posedge clk) if (ret) returnFromIrq <= 1'b1; else irqTake <= 1'b1;
    @(posedge clk) {irqTake, returnFromIrq} <= 2'b00;
    #1;
  endtask
  task automatic expire();
    @(posedge clk) watchdogExpire <= 1'b1;
    @(posedge clk) watchdogExpire <= 1'b0;
  endtask
  task automatic pins(input logic [1:0] v);
    @(posedge clk) pinLvl <= v;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Oscillator edges until release: N, or one more lost at phase entry
  task automatic wait_run(input int n);
    int cnt;
    logic prev;
    cnt = 0;
    prev = watchdogOscillator;
    repeat (3000) begin
      @(posedge clk);
      if (watchdogOscillator && !prev) cnt++;
      prev = watchdogOscillator;
      #1;
      if (!coreReset) break;
    end
    check({7'h00, cnt == n || cnt == n + 1}, 8'h01);
  endtask
  function automatic logic exp_flag(input logic [1:0] m, input logic f);
    case (m)
      SENSE_LOW_LEVEL: return 1'b0;
      SENSE_ANY_CHANGE: return 1'b1;
      SENSE_FALLING: return f;
      default: return !f;
    endcase
  endfunction
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Slow tick source, well under half the core clock
  initial begin
    watchdogOscillator = 0;
    forever begin
      repeat (3) @(posedge clk);
      watchdogOscillator <= ~watchdogOscillator;
    end
  end
  initial begin
    #200000 bad_count++;
    tally_and_finish();
  end

  initial begin
    {rst, holdLow, shortStartupFuse, seed} = {3'b111, 32'd34};
    {watchdogEnable, watchdogExpire, irqTake, returnFromIrq} = 4'h0;
    {regWrite, regRead, regAddr, regWriteData, pinLvl} = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    holdLow <= 1'b0;
    wait_run(ShortTicks);
    rd(OFS_RESET_CAUSE, 8'h01);
    wr(OFS_RESET_CAUSE, 8'h00);
    rd(OFS_RESET_CAUSE, 8'h00);
    @(posedge clk) {shortStartupFuse, holdLow} <= 2'b01;
    repeat (10) @(posedge clk);
    holdLow <= 1'b0;
    wait_run(LongTicks);
    rd(OFS_RESET_CAUSE, 8'h02);
    expire();
    repeat (3) @(posedge clk);
    #1 check({7'h00, coreReset}, 8'h00);
    @(posedge clk) watchdogEnable <= 1'b1;
    expire();
    wait_run(LongTicks);
    rd(OFS_RESET_CAUSE, 8'h02);
    wr(OFS_RESET_CAUSE, 8'h00);
    rd(OFS_RESET_CAUSE, 8'h00);
    wr(OFS_EXT_MASK, 8'hff);
    rd(OFS_EXT_MASK, 8'hc0);
    rd(8'h10, 8'h00);
    wr(OFS_EXT_MASK, 8'h00);
    repeat (16) begin
      {line, mode, fell} = 4'($random(seed));
      wr(OFS_CORE_CONTROL, 8'(mode) << (2 * line));
      pins(2'(fell) << line);
      wr(OFS_EXT_FLAGS, 8'hc0);
      pins(2'(!fell) << line);
      rd(OFS_EXT_FLAGS, 8'(exp_flag(mode, fell)) << (6 + line));
    end
    wr(OFS_CORE_CONTROL, 8'h0a);
    rd(OFS_CORE_CONTROL, 8'h0a);
    pins(2'b11);
    wr(OFS_EXT_FLAGS, 8'hc0);
    pins(2'b00);
    wr(OFS_EXT_MASK, 8'hc0);
    #1 check({7'h00, irqRequest}, 8'h00);
    wr(OFS_CORE_STATUS, 8'h80);
    repeat (2) @(posedge clk);
    #1 check({3'h0, irqVector}, {3'h0, VEC_EXT_ZERO});
    pulse(1'b0);
    check({7'h00, globalEnable}, 8'h00);
    rd(OFS_EXT_FLAGS, 8'h80);
    pulse(1'b1);
    repeat (2) @(posedge clk);
    #1 check({3'h0, irqVector}, {3'h0, VEC_EXT_ONE});
    pulse(1'b0);
    rd(OFS_EXT_FLAGS, 8'h00);
    wr(OFS_CORE_CONTROL, 8'h00);
    wr(OFS_CORE_STATUS, 8'h80);
    repeat (2) @(posedge clk);
    #1 check({3'h0, irqVector}, {3'h0, VEC_EXT_ZERO});
    rd(OFS_CORE_STATUS, 8'h80);
    rd(OFS_EXT_FLAGS, 8'h00);
    pins(2'b11);
    check({7'h00, irqRequest}, 8'h00);
    tally_and_finish();
  end
endmodule

bind ric_top ric_top_asserts #(.ShortTicks(ShortTicks),
  .LongTicks(LongTicks)) ric_top_asserts_i (.clk(clk), .rst(rst),
  .resetPinN(resetPinN), .watchdogEnable(watchdogEnable),
  .watchdogExpire(watchdogExpire), .irqTake(irqTake),
  .returnFromIrq(returnFromIrq), .regAddr(regAddr), .regRead(regRead),
  .regReadData(regReadData), .coreReset(coreReset),
  .irqRequest(irqRequest), .irqVector(irqVector),
  .globalEnable(globalEnable));

`default_nettype wire
